/* File: rtl/spep_pkg.sv */
// Constants and types for the serial program and erase port
package spep_pkg;

  // ****************************************************************
  // Serial frame layout and command codes
  // ****************************************************************
  localparam int unsigned FRAME_CMD_BITS = 4;
  localparam int unsigned FRAME_BITS     = 20;
  localparam logic [4:0]  FRAME_LAST_BIT = 5'h13;
  localparam logic [4:0]  START_TICK_BIT = 5'h03;  // 4th clock of a frame

  typedef enum logic [3:0] {
    SPEP_CMD_CORE  = 4'b0000,
    SPEP_CMD_TBLWR = 4'b1100
  } spep_cmd_t;

  // ****************************************************************
  // Core instruction subset
  // ****************************************************************
  localparam logic [7:0] OP_MOVLW  = 8'h0e;
  localparam logic [7:0] OP_MOVWF  = 8'h6e;
  localparam logic [3:0] OP_BSF    = 4'h8;
  localparam logic [3:0] OP_BCF    = 4'h9;
  localparam logic [7:0] CTRL_FILE = 8'ha6;

  // ****************************************************************
  // Pointer byte registers (data addresses)
  // ****************************************************************
  localparam logic [11:0] PTR_LOW_ADDR   = 12'hff6;
  localparam logic [11:0] PTR_MID_ADDR   = 12'hff7;
  localparam logic [11:0] PTR_UPPER_ADDR = 12'hff8;

  // ****************************************************************
  // memory_op_control field positions and reset value
  // ****************************************************************
  localparam int unsigned CTRL_PGM_BIT   = 7;
  localparam int unsigned CTRL_CFG_BIT   = 6;
  localparam int unsigned CTRL_ERASE_BIT = 4;
  localparam int unsigned CTRL_WRITE_ENABLE_BIT_BIT  = 2;
  localparam int unsigned CTRL_START_BIT = 1;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;

  // ****************************************************************
  // Program-space map
  // ****************************************************************
  localparam logic [21:0] BULK_LO_ADDR   = 22'h3c0004;
  localparam logic [21:0] BULK_HI_ADDR   = 22'h3c0005;
  localparam logic [21:0] SMALL_CODE_END = 22'h001fff;
  localparam logic [21:0] SMALL_BOOT_END = 22'h0001ff;
  localparam logic [21:0] LARGE_CODE_END = 22'h007fff;
  localparam logic [21:0] LARGE_BOOT_END = 22'h0007ff;
  localparam logic [21:0] ID_FIRST       = 22'h200000;
  localparam logic [21:0] ID_LAST        = 22'h200007;
  localparam logic [21:0] CFG_FIRST      = 22'h300000;
  localparam logic [21:0] CFG_LAST       = 22'h30000d;
  localparam logic [21:0] DEVID_FIRST    = 22'h3ffffe;
  localparam logic [21:0] DEVID_LAST     = 22'h3fffff;
  localparam int unsigned ROW_LSB        = 6;      // 64-byte rows

  // ****************************************************************
  // Bulk erase codes and target mask bit positions
  // ****************************************************************
  localparam logic [15:0] ERASE_CHIP  = 16'h0f8f;
  localparam logic [15:0] ERASE_ID    = 16'h0088;
  localparam logic [15:0] ERASE_DATA  = 16'h0084;
  localparam logic [15:0] ERASE_BOOT  = 16'h0081;
  localparam logic [15:0] ERASE_CFG   = 16'h0082;
  localparam logic [15:0] ERASE_BLK0  = 16'h0180;
  localparam logic [15:0] ERASE_BLK1  = 16'h0280;
  localparam logic [15:0] ERASE_BLK2  = 16'h0480;
  localparam logic [15:0] ERASE_BLK3  = 16'h0880;
  localparam int unsigned TGT_BOOT    = 0;        // Bits 1..4 are code blocks 0..3
  localparam int unsigned TGT_BLK0    = 1;
  localparam int unsigned TGT_ID      = 5;
  localparam int unsigned TGT_CFG     = 6;
  localparam int unsigned TGT_DATA    = 7;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLOCK_MHZ         = 50;
  localparam int unsigned BULK_ERASE_US     = 5000;
  localparam int unsigned ROW_ERASE_US      = 2000;
  localparam int unsigned BULK_ERASE_CYCLES = BULK_ERASE_US * CLOCK_MHZ;
  localparam int unsigned ROW_ERASE_CYCLES  = ROW_ERASE_US * CLOCK_MHZ;

endpackage : spep_pkg

/* File: rtl/spep_top.sv */
// Serial program and erase port: frame receiver, pointer, control and erase sequencer
// Operation
// - Small part: code to 01FFFh, boot to 01FFh
// - Large part: code to 007FFFh, boot to 0007FFh
// - ID bytes 200000h-200007h read unprotected
// - Config and part ID read unprotected
// - 22-bit pointer from three byte registers
// - Programming mode tristates unused I/O pins
// - Code operation needs bit7 set, bit6 clear
// - Start ignored unless write enable set
// - Erase bit selects erase; start bit launches
// - Two bulk registers; erase clears protection
// - Sixteen-bit erase code selects erase targets
// - Bulk erase self-timed from 4th clock
// - Only bulk erase clears code protection
// - Row erase refused when row protected
// - Row erase at second NOP, clears start
// - Any byte in row erases whole row
// - Command shifted in least significant bit first
`timescale 1ns/1ns
module spep_top
  import spep_pkg::*;
#(
  parameter bit          LARGE_PART        = 1'b1,
  parameter int unsigned BULK_ERASE_CYC    = BULK_ERASE_CYCLES,
  parameter int unsigned ROW_ERASE_CYC     = ROW_ERASE_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        prog_clock_line,
  input  wire logic        prog_data_in,
  output logic             prog_data_out,
  output logic             prog_data_oe,
  input  wire logic        hv_entry_pin,
  input  wire logic [7:0]  protect_set,
  input  wire logic [4:0]  write_protect,
  output logic             serial_prog_mode,
  output logic             unused_io_hiz,
  output logic [21:0]      program_pointer,
  output logic [7:0]       memory_op_control,
  output logic             erase_active,
  output logic             row_erase_active,
  output logic [7:0]       erase_target,
  output logic [21:0]      row_erase_addr,
  output logic             erase_refused,
  output logic [4:0]       code_protect,
  output logic             data_mem_protect,
  output logic             ptr_read_unprotected
);

  // ****************************************************************
  // State types
  // ****************************************************************
  typedef struct packed {
    logic        mode_s1;
    logic        mode_s2;
    logic [4:0]  bit_cnt;
    logic [19:0] shift;
    logic [3:0]  cmd;
    logic [15:0] payload;
    logic        word_tgl;
    logic        tick_tgl;
  } spep_link_t;

  typedef struct packed {
    logic        hv_s1;
    logic        hv_s2;
    logic [2:0]  word_sync;
    logic [2:0]  tick_sync;
    logic [7:0]  wreg;
    logic [21:0] ptr;
    logic [7:0]  ctrl;
    logic [7:0]  bulk_lo;
    logic [7:0]  bulk_hi;
    logic        bulk_armed;
    logic        last_nop;
    logic        busy;
    logic        row_mode;
    logic [19:0] timer;
    logic [7:0]  target;
    logic [7:0]  protect;
    logic [21:0] row_addr;
    logic        refused;
  } spep_main_t;

  spep_link_t lk;
  spep_link_t next_lk;
  spep_main_t st;
  spep_main_t next_st;

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Code region of an address as a one-hot target mask, zero outside code
  function automatic logic [7:0] code_region(input logic [21:0] addr);
    logic [7:0] m;
    m = 8'h00;
    if (LARGE_PART) begin
      if (addr <= LARGE_BOOT_END) begin
        m[TGT_BOOT] = 1'b1;
      end else if (addr <= LARGE_CODE_END) begin
        m[TGT_BLK0 + int'(addr[14:13])] = 1'b1;
      end
    end else begin
      if (addr <= SMALL_BOOT_END) begin
        m[TGT_BOOT] = 1'b1;
      end else if (addr <= SMALL_CODE_END) begin
        m[TGT_BLK0 + int'(addr[12])] = 1'b1;
      end
    end
    return m;
  endfunction : code_region

  // Bulk erase code to target mask; unknown codes erase nothing
  function automatic logic [7:0] bulk_targets(input logic [15:0] code);
    logic [7:0] m;
    m = 8'h00;
    unique case (code)
      ERASE_CHIP: m = 8'hff;
      ERASE_ID:   m[TGT_ID] = 1'b1;
      ERASE_DATA: m[TGT_DATA] = 1'b1;
      ERASE_BOOT: m[TGT_BOOT] = 1'b1;
      ERASE_CFG:  m[TGT_CFG] = 1'b1;
      ERASE_BLK0: m[TGT_BLK0] = 1'b1;
      ERASE_BLK1: m[TGT_BLK0 + 1] = 1'b1;
      ERASE_BLK2: m[TGT_BLK0 + 2] = 1'b1;
      ERASE_BLK3: m[TGT_BLK0 + 3] = 1'b1;
      default:    m = 8'h00;
    endcase
    return m;
  endfunction : bulk_targets

  // ****************************************************************
  // Link domain: frame receiver on the programming clock
  // ****************************************************************

  // Shift frames in, publish each by toggle, mark the 4th clock
  // The first two link clocks after entry only fill the mode sync
  always_comb begin
    next_lk = lk;
    next_lk.mode_s1 = serial_prog_mode;
    next_lk.mode_s2 = lk.mode_s1;
    if (!lk.mode_s2) begin
      next_lk.bit_cnt = 5'h00;
      next_lk.shift   = 20'h00000;
    end else begin
      next_lk.shift = {prog_data_in, lk.shift[19:1]};
      if (lk.bit_cnt == START_TICK_BIT) begin
        next_lk.tick_tgl = ~lk.tick_tgl;
      end
      if (lk.bit_cnt == FRAME_LAST_BIT) begin
        next_lk.bit_cnt  = 5'h00;
        next_lk.cmd      = next_lk.shift[FRAME_CMD_BITS-1:0];
        next_lk.payload  = next_lk.shift[FRAME_BITS-1:FRAME_CMD_BITS];
        next_lk.word_tgl = ~lk.word_tgl;
      end else begin
        next_lk.bit_cnt = lk.bit_cnt + 5'h01;
      end
    end
  end

  // Link register stage, held clear out of mode; the programmer keeps
  // the link clock low at entry, so the release meets no clock edge
  always_ff @(posedge prog_clock_line or negedge serial_prog_mode) begin
    if (!serial_prog_mode) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  // ****************************************************************
  // Main domain: command execution and erase sequencing
  // ****************************************************************
  logic       word_ev;
  logic       tick_ev;
  logic       is_nop;
  logic [7:0] op;
  logic [7:0] lit;
  logic [2:0] bitsel;
  logic [7:0] tbl_byte;
  logic [7:0] row_mask;
  logic       ctrl_code_ok;

  // Event detects read the second and third sync stages only
  assign word_ev      = st.word_sync[2] ^ st.word_sync[1];
  assign tick_ev      = st.tick_sync[2] ^ st.tick_sync[1];

  // Frame fields are read only on a word event; the link holds them
  // for a whole frame after each toggle, so no word is torn
  assign is_nop       = (lk.cmd == SPEP_CMD_CORE) && (lk.payload == 16'h0000);
  assign op           = lk.payload[15:8];
  assign lit          = lk.payload[7:0];
  assign bitsel       = op[3:1];
  assign tbl_byte     = st.ptr[0] ? lk.payload[15:8] : lk.payload[7:0];
  assign row_mask     = code_region(st.ptr);
  assign ctrl_code_ok = st.ctrl[CTRL_PGM_BIT] && !st.ctrl[CTRL_CFG_BIT];

  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.hv_s1     = hv_entry_pin;
    next_st.hv_s2     = st.hv_s1;
    next_st.word_sync = {st.word_sync[1:0], lk.word_tgl};
    next_st.tick_sync = {st.tick_sync[1:0], lk.tick_tgl};

    // Self-timed erase countdown
    // Frames that land meanwhile are dropped below
    if (st.busy) begin
      if (st.timer == 20'h00001) begin
        next_st.busy = 1'b0;
        if (st.row_mode) begin
          next_st.ctrl[CTRL_START_BIT] = 1'b0;
        end else begin
          next_st.protect = st.protect & ~st.target;
        end
      end else begin
        next_st.timer = st.timer - 20'h00001;
      end
    end

    // Frames execute only in mode and outside an erase
    if (word_ev && st.hv_s2 && !st.busy) begin
      next_st.last_nop = is_nop;
      unique case (lk.cmd)
        SPEP_CMD_CORE: begin
          if (op == OP_MOVLW) begin
            next_st.wreg = lit;
          end else if (op == OP_MOVWF) begin
            if (lit == PTR_LOW_ADDR[7:0]) begin
              next_st.ptr[7:0] = st.wreg;
            end else if (lit == PTR_MID_ADDR[7:0]) begin
              next_st.ptr[15:8] = st.wreg;
            end else if (lit == PTR_UPPER_ADDR[7:0]) begin
              next_st.ptr[21:16] = st.wreg[5:0];
            end
          end else if (lit == CTRL_FILE && !op[0]) begin
            if (op[7:4] == OP_BSF) begin
              if (int'(bitsel) != CTRL_START_BIT) begin
                next_st.ctrl[bitsel] = 1'b1;
              end else if (st.ctrl[CTRL_WRITE_ENABLE_BIT_BIT] && ctrl_code_ok) begin
                next_st.ctrl[CTRL_START_BIT] = 1'b1;
              end
            end else if (op[7:4] == OP_BCF) begin
              if (int'(bitsel) != CTRL_START_BIT) begin
                next_st.ctrl[bitsel] = 1'b0;
              end
            end
          end
        end
        SPEP_CMD_TBLWR: begin
          if (st.ptr == BULK_HI_ADDR) begin
            next_st.bulk_hi = tbl_byte;
          end else if (st.ptr == BULK_LO_ADDR) begin
            next_st.bulk_lo    = tbl_byte;
            next_st.bulk_armed = 1'b1;
          end
        end
        default: begin
          next_st.last_nop = 1'b0;
        end
      endcase
    end

    // Launch on the 4th clock of the frame after a NOP
    // A stray tick is inert unless the frame before was a NOP
    if (tick_ev && st.hv_s2 && !st.busy && st.last_nop) begin
      if (st.bulk_armed) begin
        next_st.bulk_armed = 1'b0;
        next_st.target     = bulk_targets({st.bulk_hi, st.bulk_lo});
        if (bulk_targets({st.bulk_hi, st.bulk_lo}) != 8'h00) begin
          next_st.busy     = 1'b1;
          next_st.row_mode = 1'b0;
          next_st.timer    = BULK_ERASE_CYC[19:0];
        end
      end else if (st.ctrl[CTRL_START_BIT]) begin
        if (st.ctrl[CTRL_ERASE_BIT] && row_mask != 8'h00 &&
            (row_mask & (st.protect | {3'b000, write_protect})) == 8'h00) begin
          next_st.busy     = 1'b1;
          next_st.row_mode = 1'b1;
          next_st.refused  = 1'b0;
          next_st.target   = row_mask;
          next_st.row_addr = {st.ptr[21:ROW_LSB], 6'h00};
          next_st.timer    = ROW_ERASE_CYC[19:0];
        end else begin
          next_st.ctrl[CTRL_START_BIT] = 1'b0;
          next_st.refused = st.ctrl[CTRL_ERASE_BIT];
        end
      end
    end

    // Protection set by configuration wins over any clear
    next_st.protect = next_st.protect | protect_set;
  end

  // Main register stage with synchronous reset
  always_ff @(posedge clock) begin
    if (rst) begin
      st <= '0;
      st.ctrl <= CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Mode and pin state
  // Read-back lives elsewhere, so the data pin is never driven
  assign serial_prog_mode = st.hv_s2;
  assign unused_io_hiz    = st.hv_s2;
  assign prog_data_out    = 1'b0;
  assign prog_data_oe     = 1'b0;

  // Registers and erase status
  assign program_pointer   = st.ptr;
  assign memory_op_control = st.ctrl;
  assign erase_active      = st.busy && !st.row_mode;
  assign row_erase_active  = st.busy && st.row_mode;
  assign erase_target      = st.busy ? st.target : 8'h00;
  assign row_erase_addr    = st.row_addr;
  assign erase_refused     = st.refused;
  assign code_protect      = st.protect[4:0];
  assign data_mem_protect  = ~st.protect[TGT_DATA];             // Reads zero when protected

  // ID, configuration and part ID always read normally
  assign ptr_read_unprotected =
      (st.ptr >= ID_FIRST && st.ptr <= ID_LAST) ||
      (st.ptr >= CFG_FIRST && st.ptr <= CFG_LAST) ||
      (st.ptr >= DEVID_FIRST && st.ptr <= DEVID_LAST);

endmodule : spep_top

/* File: dv/spep_monitor.sv */
// Concurrent checks on the serial program and erase port outputs
`timescale 1ns/1ns
module spep_monitor
  import spep_pkg::*;
#(
  parameter int unsigned BULK_CYC = 20,
  parameter int unsigned ROW_CYC  = 10
) (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        hv_entry_pin,
  input wire logic        serial_prog_mode,
  input wire logic        unused_io_hiz,
  input wire logic [21:0] program_pointer,
  input wire logic [7:0]  memory_op_control,
  input wire logic        erase_active,
  input wire logic        row_erase_active,
  input wire logic [7:0]  erase_target,
  input wire logic [21:0] row_erase_addr,
  input wire logic [4:0]  code_protect,
  input wire logic        ptr_read_unprotected
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [31:0] bulk_cnt;
  logic [31:0] row_cnt;
  logic        in_map;

  // ****************************************
  // Helper logic
  // ****************************************
  // Addresses that read out regardless of protection
  assign in_map = (program_pointer >= ID_FIRST && program_pointer <= ID_LAST) ||
                  (program_pointer >= CFG_FIRST && program_pointer <= CFG_LAST) ||
                  program_pointer >= DEVID_FIRST;

  // Length of the current erase in clock cycles
  always_ff @(posedge clock) begin
    if (rst) begin
      bulk_cnt <= 32'h0;
      row_cnt  <= 32'h0;
    end else begin
      bulk_cnt <= erase_active ? bulk_cnt + 32'h1 : 32'h0;
      row_cnt  <= row_erase_active ? row_cnt + 32'h1 : 32'h0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_row_start;
    $rose(row_erase_active);
  endsequence
  sequence s_code_armed;
    memory_op_control[7] && !memory_op_control[6] && memory_op_control[2];
  endsequence

  a_hiz_follows_mode: assert property (unused_io_hiz == serial_prog_mode)
    else $error("io release differs from mode");
  a_mode_entry: assert property ($rose(hv_entry_pin) |-> ##[1:4] serial_prog_mode)
    else $error("mode not entered after high voltage");
  a_ptr_read_map: assert property ($stable(program_pointer) [*2] |->
    ptr_read_unprotected == in_map)
    else $error("unprotected flag wrong for pointer");
  a_start_armed: assert property ($rose(memory_op_control[1]) |-> s_code_armed)
    else $error("start bit set without code select and enable");
  a_row_aligned: assert property (s_row_start |-> memory_op_control[4] ##[0:1]
    row_erase_addr == {program_pointer[21:6], 6'h00})
    else $error("row erase base wrong");
  a_row_length: assert property ($fell(row_erase_active) |-> row_cnt == ROW_CYC
    ##[0:2] !memory_op_control[1])
    else $error("row erase length or start clear wrong");
  a_bulk_length: assert property ($fell(erase_active) |-> bulk_cnt == BULK_CYC)
    else $error("bulk erase length wrong");
  a_target_idle: assert property (!erase_active && !row_erase_active |->
    erase_target == 8'h00)
    else $error("erase target shown while idle");
  a_protect_clear: assert property (|($past(code_protect) & ~code_protect) |->
    $past(erase_active) || $past(erase_active, 2))
    else $error("protection cleared outside bulk erase");
endmodule : spep_monitor

bind spep_top spep_monitor #(.BULK_CYC(BULK_ERASE_CYC), .ROW_CYC(ROW_ERASE_CYC)) u_mon (
  .clock(clock), .rst(rst), .hv_entry_pin(hv_entry_pin), .serial_prog_mode(serial_prog_mode),
  .unused_io_hiz(unused_io_hiz), .program_pointer(program_pointer),
  .memory_op_control(memory_op_control), .erase_active(erase_active),
  .row_erase_active(row_erase_active), .erase_target(erase_target),
  .row_erase_addr(row_erase_addr), .code_protect(code_protect),
  .ptr_read_unprotected(ptr_read_unprotected)
);

/* File: dv/spep_prog_model.sv */
// Programmer model driving link clock, link data and high-voltage entry
`timescale 1ns/1ns
module spep_prog_model (
  output logic prog_clock_line,
  output logic prog_data_in,
  output logic hv_entry_pin
);
  // ****************************************
  // Link driver
  // ****************************************
  // Link clock stands low outside frames, data held low
  initial begin
    prog_clock_line = 1'b0;
    prog_data_in    = 1'b0;
    hv_entry_pin    = 1'b0;
  end

  // Shift n bits LSB first, 160 ns period, offset off the main clock
  task automatic send_bits(input logic [19:0] f, input int n);
    #3;
    for (int i = 0; i < n; i++) begin
      prog_data_in = f[i];
      #80 prog_clock_line = 1'b1;
      #80 prog_clock_line = 1'b0;
    end
    prog_data_in = 1'b0;
  endtask : send_bits

  // Entry: lines low, high voltage, then two discarded clocks
  task automatic enter;
    prog_clock_line = 1'b0;
    prog_data_in = 1'b0;
    #100 hv_entry_pin = 1'b1;
    #1000 send_bits(20'h00000, 2);
  endtask : enter

  // One frame: command then payload
  task automatic send_frame(input logic [3:0] cmd, input logic [15:0] payload);
    send_bits({payload, cmd}, 20);
  endtask : send_frame
endmodule : spep_prog_model

/* File: dv/tb_serial_program_erase_port.sv */
// Self-checking bench for the serial program and erase port
`timescale 1ns/1ns
module tb_serial_program_erase_port;
  import spep_pkg::*;
  localparam int unsigned BULK_CYC = 20;
  localparam int unsigned ROW_CYC  = 10;
  localparam logic [15:0] CODES [9] = '{ERASE_CHIP, ERASE_ID, ERASE_DATA, ERASE_BOOT,
    ERASE_CFG, ERASE_BLK0, ERASE_BLK1, ERASE_BLK2, ERASE_BLK3};
  localparam logic [7:0]  MASKS [9] = '{8'hff, 8'h20, 8'h80, 8'h01, 8'h40, 8'h02, 8'h04,
    8'h08, 8'h10};
  localparam logic [21:0] MAP_ADDR [6] = '{22'h200000, 22'h200007, 22'h200008, 22'h30000d,
    22'h30000e, 22'h3ffffe};
  localparam logic [5:0]  MAP_EXP = 6'b101011;
  logic        clock, rst, prog_clock_line, prog_data_in, hv_entry_pin;
  logic [7:0]  protect_set, memory_op_control, erase_target;
  logic [4:0]  write_protect, code_protect;
  logic        prog_data_out, prog_data_oe, serial_prog_mode, unused_io_hiz;
  logic        erase_active, row_erase_active, erase_refused, data_mem_protect;
  logic        ptr_read_unprotected;
  logic [21:0] program_pointer, row_erase_addr;
  int          error_cnt, checks;

  // ****************************************
  // Design, programmer and clock
  // ****************************************
  spep_top #(.LARGE_PART(1'b1), .BULK_ERASE_CYC(BULK_CYC), .ROW_ERASE_CYC(ROW_CYC)) uut (
    .clock(clock), .rst(rst), .prog_clock_line(prog_clock_line), .prog_data_in(prog_data_in),
    .prog_data_out(prog_data_out), .prog_data_oe(prog_data_oe), .hv_entry_pin(hv_entry_pin),
    .protect_set(protect_set), .write_protect(write_protect),
    .serial_prog_mode(serial_prog_mode), .unused_io_hiz(unused_io_hiz),
    .program_pointer(program_pointer), .memory_op_control(memory_op_control),
    .erase_active(erase_active), .row_erase_active(row_erase_active),
    .erase_target(erase_target), .row_erase_addr(row_erase_addr),
    .erase_refused(erase_refused), .code_protect(code_protect),
    .data_mem_protect(data_mem_protect), .ptr_read_unprotected(ptr_read_unprotected));
  spep_prog_model u_prog (.prog_clock_line(prog_clock_line), .prog_data_in(prog_data_in),
    .hv_entry_pin(hv_entry_pin));

  // 50 MHz main clock
  always #10 clock = ~clock;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic core(input logic [7:0] op, input logic [7:0] lit);
    u_prog.send_frame(SPEP_CMD_CORE, {op, lit});
  endtask : core

  // Pointer load through core instructions
  task automatic set_ptr(input logic [21:0] a);
    core(OP_MOVLW, {2'b00, a[21:16]});
    core(OP_MOVWF, PTR_UPPER_ADDR[7:0]);
    core(OP_MOVLW, a[15:8]);
    core(OP_MOVWF, PTR_MID_ADDR[7:0]);
    core(OP_MOVLW, a[7:0]);
    core(OP_MOVWF, PTR_LOW_ADDR[7:0]);
  endtask : set_ptr

  task automatic bit_op(input logic [3:0] op, input logic [2:0] b);
    core({op, b, 1'b0}, CTRL_FILE);
  endtask : bit_op

  task automatic settle;
    repeat (10) @(negedge clock);
  endtask : settle

  // Second no-op while timing the erase it launches
  task automatic nop_watch(input logic row, output int unsigned len, output logic [7:0] tgt);
    len = 0;
    tgt = 8'h00;
    fork
      core(8'h00, 8'h00);
      begin
        for (int w = 0; w < 200 && !(row ? row_erase_active : erase_active); w++)
          @(negedge clock);
        tgt = erase_target;
        while ((row ? row_erase_active : erase_active) && len < 200) begin
          @(negedge clock);
          len++;
        end
      end
    join
  endtask : nop_watch

  task automatic bulk(input logic [15:0] code);
    core(OP_MOVLW, 8'h05);
    core(OP_MOVWF, PTR_LOW_ADDR[7:0]);
    u_prog.send_frame(SPEP_CMD_TBLWR, {code[15:8], code[15:8]});
    core(OP_MOVLW, 8'h04);
    core(OP_MOVWF, PTR_LOW_ADDR[7:0]);
    u_prog.send_frame(SPEP_CMD_TBLWR, {code[7:0], code[7:0]});
    core(8'h00, 8'h00);
  endtask : bulk

  task automatic row_try(input logic [21:0] a, input logic [4:0] wp, input int unsigned n);
    int unsigned len;
    logic [7:0]  tgt;
    @(negedge clock);
    write_protect = wp;
    bit_op(OP_BSF, 3'd7);
    bit_op(OP_BCF, 3'd6);
    set_ptr(a);
    bit_op(OP_BSF, 3'd2);
    bit_op(OP_BSF, 3'd4);
    bit_op(OP_BSF, 3'd1);
    core(8'h00, 8'h00);
    nop_watch(1'b1, len, tgt);
    settle();
    check("row length", len, n);
    check("start bit", memory_op_control[1], 1'b0);
    check("refused", erase_refused, n == 0);
  endtask : row_try

  // ****************************************
  // Tests
  // ****************************************
  int unsigned blen;
  logic [7:0]  btgt;
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    protect_set = 8'h00;
    write_protect = 5'h00;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    check("reset ptr", program_pointer, 22'h000000);
    check("reset ctrl", memory_op_control, CTRL_RESET);
    check("reset flags", {serial_prog_mode, erase_active, code_protect, data_mem_protect}, 8'h01);
    u_prog.enter();
    check("mode", {serial_prog_mode, unused_io_hiz, prog_data_oe, prog_data_out}, 4'b1100);
    // Map of always-readable locations
    for (int i = 0; i < 6; i++) begin
      set_ptr(MAP_ADDR[i]);
      settle();
      check("pointer", program_pointer, MAP_ADDR[i]);
      check("unprotected", ptr_read_unprotected, MAP_EXP[i]);
    end
    // Start bit refused without enable or with config select
    bit_op(OP_BSF, 3'd7);
    bit_op(OP_BCF, 3'd6);
    bit_op(OP_BSF, 3'd4);
    bit_op(OP_BSF, 3'd1);
    settle();
    check("ctrl no enable", memory_op_control, 8'h90);
    bit_op(OP_BSF, 3'd6);
    bit_op(OP_BSF, 3'd2);
    bit_op(OP_BSF, 3'd1);
    settle();
    check("ctrl config", memory_op_control, 8'hd4);
    bit_op(OP_BCF, 3'd2);
    // Every bulk erase code on a fully protected part
    set_ptr(BULK_HI_ADDR);
    for (int i = 0; i < 9; i++) begin
      @(negedge clock);
      protect_set = 8'hff;
      @(negedge clock);
      protect_set = 8'h00;
      bulk(CODES[i]);
      nop_watch(1'b0, blen, btgt);
      settle();
      check("target", btgt, MASKS[i]);
      check("bulk length", blen, BULK_CYC);
      check("protect", code_protect, 5'h1f & ~MASKS[i][4:0]);
      check("data protect", data_mem_protect, MASKS[i][7]);
    end
    // Row erase: protected, write protected, last row, outside code
    row_try(22'h000123, 5'h00, 0);
    check("protect kept", code_protect, 5'h0f);
    row_try(22'h006050, 5'h10, 0);
    row_try(22'h007fff, 5'h00, ROW_CYC);
    check("row base", row_erase_addr, 22'h007fc0);
    row_try(22'h008010, 5'h00, 0);
    end_sim();
  end

  // Watchdog well beyond the expected run
  initial begin
    #1500000;
    error_cnt++;
    end_sim();
  end
endmodule : tb_serial_program_erase_port
